// >>> core/bus_seq_pkg.sv
/*
 Constants for the external bus sequencer: widths, phase counts, reset figures.
 Assumes a single 125 MHz system clock that stands in for the master clock.
*/
package bus_seq_pkg;
   localparam int unsigned ADDR_W          = 12;
   localparam int unsigned DATA_W          = 16;
   localparam int unsigned PHASES_PER_MC   = 4;
   localparam logic [1:0]  PHASE_LAST      = 2'h3;
   localparam logic [1:0]  PHASE_STROBE_ON = 2'h1;
   localparam logic [1:0]  PHASE_WE_ON     = 2'h2;
   localparam int unsigned RESET_MIN_MC    = 5;
   localparam logic [2:0]  RESET_CNT_MAX   = 3'h5;
   localparam logic [11:0] PC_RESET        = 12'h000;

   typedef enum logic [2:0]
   {
      SLOT_FETCH  = 3'b000,
      SLOT_DUMMY  = 3'b001,
      SLOT_DATA   = 3'b011,
      SLOT_RESET  = 3'b010,
      SLOT_IO     = 3'b110
   } slot_t;
endpackage : bus_seq_pkg

// >>> core/bus_reset_and_table_cycles.sv
/*
 External bus master: reset handling, strobe generation, table-read and
 table-write slot sequences, machine cycle clock from the system clock.
 Assumes the core supplies operation requests as levels sampled at slot end.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - While reset is held all three strobes stay high and the data bus is released.
// - After reset falls the program counter and address outputs clear after one full machine cycle.
// - After reset rises execution resumes once one full machine cycle has completed.
// - Reset may change at any time and is synchronised to the machine cycle.
// - At most one of the three strobes is low at any time.
// - Reset during a write cycle may leave an invalid write address on the bus.
// - Table read runs prefetch, dummy prefetch, data fetch, next prefetch.
// - Table write runs prefetch, dummy prefetch, write slot, next prefetch.
// - Table write drives valid data before the next instruction fetch.
// - The machine cycle clock is four system clock periods long.
module bus_reset_and_table_cycles
(
   input  wire logic                         clk,
   input  wire logic                         arst_n,
   input  wire logic                         reset_in_n,
   input  wire logic                         table_read_op,
   input  wire logic                         table_write_op,
   input  wire logic                         port_op,
   input  wire logic                         port_write,
   input  wire logic [2:0]                   port_addr,
   input  wire logic [bus_seq_pkg::ADDR_W-1:0] table_addr,
   input  wire logic [bus_seq_pkg::DATA_W-1:0] write_data,
   input  wire logic [bus_seq_pkg::DATA_W-1:0] data_bus_in,
   output logic [bus_seq_pkg::DATA_W-1:0]    data_bus_out,
   output logic                              data_bus_oe,
   output logic [bus_seq_pkg::ADDR_W-1:0]    address_outputs,
   output logic                              machine_cycle_clock,
   output logic                              program_mem_strobe_n,
   output logic                              peripheral_strobe_n,
   output logic                              write_strobe_n,
   output logic [bus_seq_pkg::DATA_W-1:0]    fetched_word,
   output logic                              fetched_valid,
   output logic [bus_seq_pkg::DATA_W-1:0]    table_data,
   output logic                              table_data_valid,
   output logic                              running
);

   ////////////////////////////////////////////////////////////////////////////
   logic                              rst_s1_r;
   logic                              rst_s2_r;
   logic [1:0]                        phase_r;
   logic                              slot_end;
   logic                              rs_s1_r;
   logic                              rs_s2_r;
   logic                              in_reset_r;
   logic                              resume_r;
   bus_seq_pkg::slot_t                slot_r;
   bus_seq_pkg::slot_t                slot_nxt;
   logic                              tbl_write_r;
   logic                              io_write_r;
   logic [bus_seq_pkg::ADDR_W-1:0]    pc_r;
   logic                              acc_write;
   logic                              acc_io;

   // Internal reset release through two flops
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Machine cycle divider; clock high in phases 2..3 so it falls at slot end
   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
         phase_r <= 2'h0;
      else
         phase_r <= phase_r + 2'h1;
   end

   assign slot_end = (phase_r == bus_seq_pkg::PHASE_LAST);
   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
         machine_cycle_clock <= 1'b0;
      else
         machine_cycle_clock <= ^phase_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset pin: two flops; run state changes at machine cycle boundaries, strobes and bus drive drop at once
   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
      begin
         rs_s1_r <= 1'b0;
         rs_s2_r <= 1'b0;
      end
      else
      begin
         rs_s1_r <= reset_in_n;
         rs_s2_r <= rs_s1_r;
      end
   end
   // Latency varies up to one machine cycle with where the edge lands
   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
      begin
         in_reset_r <= 1'b1;
         resume_r   <= 1'b0;
      end
      else if (slot_end)
      begin
         if (!rs_s2_r)
         begin
            in_reset_r <= 1'b1;
            resume_r   <= 1'b0;
         end
         else if (in_reset_r && !resume_r)
            resume_r <= 1'b1;
         else if (resume_r)
         begin
            in_reset_r <= 1'b0;
            resume_r   <= 1'b0;
         end
      end
   end
   assign running = !in_reset_r;

   ////////////////////////////////////////////////////////////////////////////
   // Slot sequencer
   always_comb
   begin
      slot_nxt = bus_seq_pkg::SLOT_FETCH;
      case (slot_r)
         bus_seq_pkg::SLOT_FETCH:
            if (table_read_op || table_write_op)
               slot_nxt = bus_seq_pkg::SLOT_DUMMY;
            else if (port_op)
               slot_nxt = bus_seq_pkg::SLOT_IO;
         bus_seq_pkg::SLOT_DUMMY:
            slot_nxt = bus_seq_pkg::SLOT_DATA;
         bus_seq_pkg::SLOT_DATA:
            slot_nxt = bus_seq_pkg::SLOT_FETCH;
         bus_seq_pkg::SLOT_IO:
            slot_nxt = bus_seq_pkg::SLOT_FETCH;
         bus_seq_pkg::SLOT_RESET:
            slot_nxt = bus_seq_pkg::SLOT_FETCH;
         default:
            slot_nxt = bus_seq_pkg::SLOT_RESET;
      endcase
   end

   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
      begin
         slot_r      <= bus_seq_pkg::SLOT_RESET;
         tbl_write_r <= 1'b0;
         io_write_r  <= 1'b0;
      end
      else if (slot_end)
      begin
         if (in_reset_r)
            slot_r <= bus_seq_pkg::SLOT_RESET;
         else
            slot_r <= slot_nxt;
         if (slot_r == bus_seq_pkg::SLOT_FETCH)
         begin
            tbl_write_r <= table_write_op && !table_read_op;
            io_write_r  <= port_write;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter and address outputs
   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
      begin
         pc_r            <= bus_seq_pkg::PC_RESET;
         address_outputs <= bus_seq_pkg::PC_RESET;
      end
      else if (slot_end)
      begin
         if (in_reset_r)
         begin
            pc_r            <= bus_seq_pkg::PC_RESET;
            address_outputs <= bus_seq_pkg::PC_RESET;
         end
         else
            case (slot_nxt)
               bus_seq_pkg::SLOT_FETCH:
               begin
                  address_outputs <= pc_r;
                  pc_r            <= pc_r + 12'h001;
               end
               bus_seq_pkg::SLOT_DUMMY:
                  address_outputs <= pc_r;
               bus_seq_pkg::SLOT_DATA:
                  address_outputs <= table_addr;
               bus_seq_pkg::SLOT_IO:
                  address_outputs <= {9'h1FF, port_addr};
               default:
                  address_outputs <= pc_r;
            endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strobes; all high in the first phase of each slot, so a read strobe stays low up to the sample
   assign acc_write = (slot_r == bus_seq_pkg::SLOT_DATA && tbl_write_r) ||
                      (slot_r == bus_seq_pkg::SLOT_IO && io_write_r);
   assign acc_io    = (slot_r == bus_seq_pkg::SLOT_IO);

   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
      begin
         program_mem_strobe_n <= 1'b1;
         peripheral_strobe_n  <= 1'b1;
         write_strobe_n       <= 1'b1;
      end
      else if (in_reset_r || !rs_s2_r || slot_r == bus_seq_pkg::SLOT_RESET || slot_end)
      begin
         program_mem_strobe_n <= 1'b1;
         peripheral_strobe_n  <= 1'b1;
         write_strobe_n       <= 1'b1;
      end
      else
      begin
         program_mem_strobe_n <= !(!acc_write && !acc_io);
         peripheral_strobe_n  <= !(!acc_write && acc_io);
         write_strobe_n       <= !(acc_write && phase_r == 2'h1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data bus drive and capture; sample at machine clock fall
   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
      begin
         data_bus_out <= '0;
         data_bus_oe  <= 1'b0;
      end
      else if (in_reset_r || !rs_s2_r)
         data_bus_oe <= 1'b0;
      else
      begin
         data_bus_out <= write_data;
         data_bus_oe  <= acc_write && (phase_r != bus_seq_pkg::PHASE_LAST);
      end
   end

   always_ff @(posedge clk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
      begin
         fetched_word     <= '0;
         fetched_valid    <= 1'b0;
         table_data       <= '0;
         table_data_valid <= 1'b0;
      end
      else
      begin
         fetched_valid    <= 1'b0;
         table_data_valid <= 1'b0;
         if (slot_end && !in_reset_r)
         begin
            if (slot_r == bus_seq_pkg::SLOT_FETCH)
            begin
               fetched_word  <= data_bus_in;
               fetched_valid <= 1'b1;
            end
            if ((slot_r == bus_seq_pkg::SLOT_DATA && !tbl_write_r) ||
                (acc_io && !io_write_r))
            begin
               table_data       <= data_bus_in;
               table_data_valid <= 1'b1;
            end
         end
      end
   end

endmodule : bus_reset_and_table_cycles

// >>> sim/bus_seq_checker.sv
/*
 Concurrent checks on the bus sequencer ports.
 Assumes one clock, clk, and the asynchronous reset arst_n.
*/
`timescale 1ns/1ps

module bus_seq_checker
(
   input wire logic                             clk,
   input wire logic                             arst_n,
   input wire logic                             reset_in_n,
   input wire logic                             running,
   input wire logic                             data_bus_oe,
   input wire logic [bus_seq_pkg::ADDR_W-1:0]   address_outputs,
   input wire logic                             machine_cycle_clock,
   input wire logic                             program_mem_strobe_n,
   input wire logic                             peripheral_strobe_n,
   input wire logic                             write_strobe_n,
   input wire logic                             table_data_valid
);
   logic [4:0] low_cnt_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // Saturating count of reset pin low time
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         low_cnt_r <= 5'h00;
      else if (reset_in_n)
         low_cnt_r <= 5'h00;
      else if (low_cnt_r != 5'h1F)
         low_cnt_r <= low_cnt_r + 5'h01;
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_reset_quiet;
      !running |-> program_mem_strobe_n && peripheral_strobe_n && write_strobe_n && !data_bus_oe;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("strobe or bus active in reset");
   property p_addr_clear;
      (low_cnt_r == 5'h14) |-> (address_outputs == 12'h000);
   endproperty
   a_addr_clear: assert property (p_addr_clear) else $error("address not cleared in reset");
   property p_resume;
      $rose(reset_in_n) && (low_cnt_r >= 5'h14) |-> ##[6:12] running;
   endproperty
   a_resume: assert property (p_resume) else $error("no resume after reset release");
   property p_exclusive;
      $onehot0({~program_mem_strobe_n, ~peripheral_strobe_n, ~write_strobe_n});
   endproperty
   a_exclusive: assert property (p_exclusive) else $error("two strobes low together");
   property p_write_drive;
      !write_strobe_n |-> data_bus_oe;
   endproperty
   a_write_drive: assert property (p_write_drive) else $error("write without bus drive");
   property p_write_pulse;
      $fell(write_strobe_n) |=> write_strobe_n;
   endproperty
   a_write_pulse: assert property (p_write_pulse) else $error("write strobe too long");
   property p_mclk;
      $rose(machine_cycle_clock) |-> ##4 $rose(machine_cycle_clock);
   endproperty
   a_mclk: assert property (p_mclk) else $error("machine clock period wrong");
   property p_mem_strobe;
      disable iff (!arst_n || !reset_in_n)
      $fell(program_mem_strobe_n) |-> !program_mem_strobe_n [*3] ##1 program_mem_strobe_n;
   endproperty
   a_mem_strobe: assert property (p_mem_strobe) else $error("memory strobe width wrong");
   property p_valid_pulse;
      table_data_valid |=> !table_data_valid;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("table data valid too long");
endmodule : bus_seq_checker

bind bus_reset_and_table_cycles bus_seq_checker bus_seq_checker_i
(
   .clk(clk), .arst_n(arst_n), .reset_in_n(reset_in_n), .running(running),
   .data_bus_oe(data_bus_oe), .address_outputs(address_outputs),
   .machine_cycle_clock(machine_cycle_clock), .program_mem_strobe_n(program_mem_strobe_n),
   .peripheral_strobe_n(peripheral_strobe_n), .write_strobe_n(write_strobe_n),
   .table_data_valid(table_data_valid)
);

// >>> sim/ext_bus_model.sv
/*
 External memory and peripherals: answer a read strobe with a word made from the address.
 Assumes the sequencer samples read data at the end of each strobed slot.
*/
`timescale 1ns/1ps

module ext_bus_model
(
   input  wire logic                             clk,
   input  wire logic [bus_seq_pkg::ADDR_W-1:0]   address_outputs,
   input  wire logic                             program_mem_strobe_n,
   input  wire logic                             peripheral_strobe_n,
   output logic [bus_seq_pkg::DATA_W-1:0]        data_bus_in
);
   logic                           sel;
   logic [bus_seq_pkg::DATA_W-1:0] last_r;

   assign sel = !program_mem_strobe_n || !peripheral_strobe_n;
   // Released bus shows the inverse, so a late sample cannot pass by luck
   assign data_bus_in = sel ? {4'h5, address_outputs} : ~last_r;
   always_ff @(posedge clk)
   begin
      if (sel)
         last_r <= {4'h5, address_outputs};
   end
endmodule : ext_bus_model

// >>> sim/bus_reset_and_table_cycles_bench.sv
/*
 Self-checking bench: reset, table read, table write, port access, reset during write.
 Assumes the sequencer header as declared and the external bus model.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD t=%0t got %h exp %h", $time, a, b); end end

module bus_reset_and_table_cycles_bench;
   logic        clk = 0, arst_n = 0, reset_in_n = 0;
   logic        table_read_op = 0, table_write_op = 0, port_op = 0, port_write = 0;
   logic [2:0]  port_addr = 3'h0;
   logic [11:0] table_addr = 12'h000;
   logic [15:0] write_data = 16'h0000, data_bus_in, data_bus_out, fetched_word, table_data;
   logic        data_bus_oe, machine_cycle_clock, program_mem_strobe_n, peripheral_strobe_n;
   logic        write_strobe_n, fetched_valid, table_data_valid, running;
   logic [11:0] address_outputs;
   int          fail_count = 0, num_checks = 0, cycles = 0;

   bus_reset_and_table_cycles bus_reset_and_table_cycles_i (.clk(clk), .arst_n(arst_n),
      .reset_in_n(reset_in_n), .table_read_op(table_read_op), .table_write_op(table_write_op),
      .port_op(port_op), .port_write(port_write), .port_addr(port_addr),
      .table_addr(table_addr), .write_data(write_data), .data_bus_in(data_bus_in),
      .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
      .address_outputs(address_outputs), .machine_cycle_clock(machine_cycle_clock),
      .program_mem_strobe_n(program_mem_strobe_n), .peripheral_strobe_n(peripheral_strobe_n),
      .write_strobe_n(write_strobe_n), .fetched_word(fetched_word),
      .fetched_valid(fetched_valid), .table_data(table_data),
      .table_data_valid(table_data_valid), .running(running));
   ext_bus_model ext_bus_model_i (.clk(clk), .address_outputs(address_outputs),
      .program_mem_strobe_n(program_mem_strobe_n), .peripheral_strobe_n(peripheral_strobe_n),
      .data_bus_in(data_bus_in));

   initial
   begin
      forever #4 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   // Hold pin low past the minimum, then release and wait for run
   task automatic pin_reset;
      reset_in_n = 0;
      step(30);
      `CHK({program_mem_strobe_n, peripheral_strobe_n, write_strobe_n}, 3'h7)
      `CHK(data_bus_oe, 1'b0)
      `CHK(address_outputs, 12'h000)
      reset_in_n = 1;
      for (int i = 0; i < 40 && running !== 1'b1; i++) step(1);
      `CHK(running, 1'b1)
      for (int i = 0; i < 20 && fetched_valid !== 1'b1; i++) step(1);
      `CHK(fetched_word, 16'h5000)
      $display("test reset done");
   endtask : pin_reset

   task automatic table_read(logic [11:0] a);
      table_addr = a;
      table_read_op = 1;
      for (int i = 0; i < 60 && table_data_valid !== 1'b1; i++) step(1);
      `CHK(table_data, {4'h5, a})
      table_read_op = 0;
      step(1);
      $display("test read done");
   endtask : table_read

   // Port or table write; port address carries ones above the port field
   task automatic bus_write(logic port, logic [11:0] a, logic [15:0] d);
      port_op = port;
      port_write = port;
      table_write_op = !port;
      port_addr = a[2:0];
      table_addr = a;
      write_data = d;
      for (int i = 0; i < 60 && write_strobe_n !== 1'b0; i++) step(1);
      `CHK(data_bus_oe, 1'b1)
      `CHK(data_bus_out, d)
      `CHK(address_outputs, port ? {9'h1FF, a[2:0]} : a)
      {port_op, port_write, table_write_op} = 3'h0;
      step(1);
      $display("test write done");
   endtask : bus_write

   task automatic port_read(logic [2:0] p);
      port_addr = p;
      port_op = 1;
      for (int i = 0; i < 60 && peripheral_strobe_n !== 1'b0; i++) step(1);
      `CHK(address_outputs, {9'h1FF, p})
      for (int i = 0; i < 8 && table_data_valid !== 1'b1; i++) step(1);
      `CHK(table_data, {4'h5, 9'h1FF, p})
      port_op = 0;
      step(1);
      $display("test port done");
   endtask : port_read

   // Cut a write short with a pin reset; strobes, bus release and the cleared address are judged, then the same address is read
   task automatic write_cut;
      table_addr = 12'h0A5;
      write_data = 16'hBEEF;
      table_write_op = 1;
      for (int i = 0; i < 60 && write_strobe_n !== 1'b0; i++) step(1);
      table_write_op = 0;
      pin_reset();
      table_read(12'h0A5);
      $display("test cut done");
   endtask : write_cut

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         give_verdict();
      end
   end

   initial
   begin
      step(4);
      arst_n = 1;
      pin_reset();
      table_read(12'h000);
      table_read(12'hFFF);
      table_read(12'h3C3);
      bus_write(0, 12'h155, 16'hA5C3);
      bus_write(1, 12'h006, 16'h1234);
      port_read(3'h5);
      write_cut();
      give_verdict();
   end
endmodule : bus_reset_and_table_cycles_bench
